//--- design/pfp_flag_port.sv
/*
 * programmable flag port: eight two-way flag pins with direction and value
 * registers, three dedicated output flags and the fixed input/output flag
 * pair that borrows serial port one pins, all behind an axi4-lite slave.
 * assumes pins are resolved by the surroundings from dout and oe_n, and
 * that serial port one logic sits outside and is steered by fixed_sel.
 */
// Local design decisions: register access over AXI4-Lite and the address map.
module pfp_flag_port (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [pfp_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [pfp_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// programmable flag pins
	input wire logic [pfp_pkg::FLAG_W-1:0] programmable_flag_pin_in,
	output pfp_pkg::pfp_pins_s programmable_flag_pin_out,
	// fixed-mode flags
	input wire logic fixed_flag_input,
	output pfp_pkg::pfp_fixed_s fixed_flags,
	// configuration levels caught at reset release
	output logic [pfp_pkg::CFG_W-1:0] config_straps
);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	logic [pfp_pkg::FLAG_W-1:0] flag_direction_reg;
	logic [pfp_pkg::FLAG_W-1:0] flag_value_reg;
	logic [pfp_pkg::FLAG_W-1:0] sync1_reg, sync2_reg, sync3_reg, pin_level_reg;
	logic fi_sync1_reg, fi_sync2_reg, fi_sync3_reg, fi_level_reg;
	logic [pfp_pkg::DED_W-1:0] dedicated_reg;
	logic fixed_out_reg, fixed_sel_reg;
	logic [pfp_pkg::CFG_W-1:0] config_reg;
	logic strap_taken_reg;
	logic aw_held_reg, w_held_reg;
	logic [pfp_pkg::ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;

	// --------------------------------------------------------------
	// pin input synchronisers
	// --------------------------------------------------------------
	// three stages; a level counts only when stages two and three agree
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
			sync3_reg <= 8'h00;
			pin_level_reg <= 8'h00;
			fi_sync1_reg <= 1'b0;
			fi_sync2_reg <= 1'b0;
			fi_sync3_reg <= 1'b0;
			fi_level_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= programmable_flag_pin_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			fi_sync1_reg <= fixed_flag_input;
			fi_sync2_reg <= fi_sync1_reg;
			fi_sync3_reg <= fi_sync2_reg;
			fi_level_reg <= (fi_sync2_reg == fi_sync3_reg) ? fi_sync3_reg : fi_level_reg;
			// a bit whose stages disagree keeps its old level, so a one-cycle glitch never reads
			pin_level_reg <= (sync3_reg & ~(sync2_reg ^ sync3_reg))
				| (pin_level_reg & (sync2_reg ^ sync3_reg));
		end
	end

	// --------------------------------------------------------------
	// configuration straps
	// --------------------------------------------------------------
	// caught on the first edge after release; pins are undriven until then
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			strap_taken_reg <= 1'b0;
			config_reg <= 4'h0;
		end
		else if (!strap_taken_reg)
		begin
			strap_taken_reg <= 1'b1;
			config_reg <= programmable_flag_pin_in[pfp_pkg::CFG_W-1:0];
		end
	end

	// --------------------------------------------------------------
	// axi write path
	// --------------------------------------------------------------
	wire do_write = aw_held_reg && w_held_reg && !bvalid;
	wire [3:0] wr_idx = aw_addr_reg[5:2];
	wire wr_dir = wr_idx == pfp_pkg::OFS_DIRECTION[5:2];
	wire wr_val = wr_idx == pfp_pkg::OFS_VALUE[5:2];
	wire wr_fix = wr_idx == pfp_pkg::OFS_FIXED[5:2];
	wire wr_hit = wr_dir || wr_val || wr_fix;

	// address and data accepted in either order, then one response
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			bvalid <= 1'b0;
			bresp <= pfp_pkg::RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_held_reg <= 1'b1;
				awready <= 1'b0;
				aw_addr_reg <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_held_reg <= 1'b1;
				wready <= 1'b0;
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
			end
			if (do_write)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
				bvalid <= 1'b1;
				bresp <= (wr_hit && aw_addr_reg[7:6] == 2'h0) ? pfp_pkg::RESP_OKAY
					: pfp_pkg::RESP_SLVERR;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end


	// --------------------------------------------------------------
	// flag registers
	// --------------------------------------------------------------
	wire wr_ok = do_write && aw_addr_reg[7:6] == 2'h0 && w_strb_reg[0];

	// reset clears direction so every pin is an input while reset holds
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			flag_direction_reg <= pfp_pkg::RST_DIRECTION;
			flag_value_reg <= pfp_pkg::RST_VALUE;
			dedicated_reg <= pfp_pkg::RST_DEDICATED;
			fixed_out_reg <= 1'b0;
			fixed_sel_reg <= 1'b0;
		end
		else
		begin
			if (wr_ok && wr_dir)
				flag_direction_reg <= w_data_reg[7:0];
			if (wr_ok && wr_val)
				flag_value_reg <= w_data_reg[7:0];
			if (wr_ok && wr_fix)
			begin
				dedicated_reg <= w_data_reg[pfp_pkg::FIX_DED_LSB +: pfp_pkg::DED_W];
				fixed_out_reg <= w_data_reg[pfp_pkg::FIX_FO_BIT];
				fixed_sel_reg <= w_data_reg[pfp_pkg::FIX_SEL_BIT];
			end
		end
	end

	// --------------------------------------------------------------
	// pin and fixed flag outputs, straight from flip-flops
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			programmable_flag_pin_out.dout <= 8'h00;
			programmable_flag_pin_out.oe_n <= 8'hFF;
			fixed_flags <= '0;
			config_straps <= 4'h0;
		end
		else
		begin
			programmable_flag_pin_out.dout <= flag_value_reg;
			programmable_flag_pin_out.oe_n <= ~flag_direction_reg;
			fixed_flags.dedicated <= dedicated_reg;
			fixed_flags.fixed_out <= fixed_out_reg & fixed_sel_reg;
			fixed_flags.fixed_sel <= fixed_sel_reg;
			config_straps <= config_reg;
		end
	end

	// --------------------------------------------------------------
	// axi read path
	// --------------------------------------------------------------
	wire [3:0] rd_idx = araddr[5:2];
	wire rd_low = araddr[7:6] == 2'h0;
	// outputs read the driven value, inputs the synchronised pin
	wire [7:0] value_view = (flag_direction_reg & flag_value_reg)
		| (~flag_direction_reg & pin_level_reg);
	wire [31:0] fixed_view = {23'h000000, fi_level_reg & fixed_sel_reg, 3'h0,
		fixed_sel_reg, fixed_out_reg, dedicated_reg};
	wire rd_dir = rd_low && rd_idx == pfp_pkg::OFS_DIRECTION[5:2];
	wire rd_val = rd_low && rd_idx == pfp_pkg::OFS_VALUE[5:2];
	wire rd_fix = rd_low && rd_idx == pfp_pkg::OFS_FIXED[5:2];
	wire rd_cfg = rd_low && rd_idx == pfp_pkg::OFS_CONFIG[5:2];
	wire [31:0] rd_mux = rd_dir ? {24'h000000, flag_direction_reg}
		: rd_val ? {24'h000000, value_view}
		: rd_fix ? fixed_view
		: rd_cfg ? {28'h0000000, config_reg} : 32'h00000000;

	// one read at a time; arready drops while the answer is out
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= pfp_pkg::RESP_OKAY;
			arready <= 1'b1;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_mux;
			rresp <= (rd_dir || rd_val || rd_fix || rd_cfg) ? pfp_pkg::RESP_OKAY
				: pfp_pkg::RESP_SLVERR;
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	AST_DIR_DRIVES_OE: assert property (@(posedge clk) disable iff (!arst_n)
		programmable_flag_pin_out.oe_n == ~$past(flag_direction_reg))
		else $error("pin enable does not follow direction");
	AST_INPUT_HIGHZ: assert property (@(posedge clk) disable iff (!arst_n)
		$past(flag_direction_reg[0]) == 1'b0 |-> programmable_flag_pin_out.oe_n[0])
		else $error("input pin is driven");
	AST_DOUT_FOLLOWS: assert property (@(posedge clk) disable iff (!arst_n)
		wr_ok && wr_val |-> ##2 programmable_flag_pin_out.dout == $past(w_data_reg[7:0], 2))
		else $error("value write not driven");
	AST_OUT_READBACK: assert property (@(posedge clk) disable iff (!arst_n)
		arvalid && arready && rd_val |=> rdata[7:0] ==
		(($past(flag_direction_reg) & $past(flag_value_reg)) |
		(~$past(flag_direction_reg) & $past(pin_level_reg))))
		else $error("value read mismatch");
	AST_INPUT_SYNC: assert property (@(posedge clk) disable iff (!arst_n)
		(sync2_reg[0] == sync3_reg[0]) |=> pin_level_reg[0] == $past(sync3_reg[0]))
		else $error("synchronised input not taken");
	AST_RESET_INPUTS: assert property (@(posedge clk)
		!arst_n |-> programmable_flag_pin_out.oe_n == 8'hFF)
		else $error("pin driven in reset");
	AST_FO_GATED: assert property (@(posedge clk) disable iff (!arst_n)
		!$past(fixed_sel_reg) |-> !fixed_flags.fixed_out)
		else $error("fixed output without alternate select");
	AST_DED_OUT: assert property (@(posedge clk) disable iff (!arst_n)
		wr_ok && wr_fix |-> ##2 fixed_flags.dedicated == $past(w_data_reg[2:0], 2))
		else $error("dedicated flags not driven");
	AST_READ_ANSWER: assert property (@(posedge clk) disable iff (!arst_n)
		arvalid && arready |=> rvalid)
		else $error("read not answered in one cycle");
	COV_WRITE_DIR: cover property (@(posedge clk) disable iff (!arst_n) wr_ok && wr_dir);
	COV_READ_VAL: cover property (@(posedge clk) disable iff (!arst_n)
		arvalid && arready && rd_val);
	COV_SEL_FIXED: cover property (@(posedge clk) disable iff (!arst_n) fixed_sel_reg);

endmodule : pfp_flag_port

//--- design/pfp_pkg.sv
/*
 * package for the programmable flag port: register map, field widths,
 * reset values, axi4-lite response codes, carrier structs.
 * assumes a single 10 MHz core clock and an axi4-lite register bus.
 */
package pfp_pkg;

	// --------------------------------------------------------------
	// widths
	// --------------------------------------------------------------
	localparam int FLAG_W = 8;
	localparam int CFG_W = 4;
	localparam int DED_W = 3;
	localparam int ADDR_W = 8;

	// --------------------------------------------------------------
	// register byte offsets
	// --------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_DIRECTION = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_VALUE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_FIXED = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h0C;

	// --------------------------------------------------------------
	// fixed register field positions
	// --------------------------------------------------------------
	localparam int FIX_DED_LSB = 0;
	localparam int FIX_FO_BIT = 3;
	localparam int FIX_SEL_BIT = 4;
	localparam int FIX_FI_BIT = 8;

	// --------------------------------------------------------------
	// reset values
	// --------------------------------------------------------------
	localparam logic [FLAG_W-1:0] RST_DIRECTION = 8'h00;
	localparam logic [FLAG_W-1:0] RST_VALUE = 8'h00;
	localparam logic [DED_W-1:0] RST_DEDICATED = 3'h0;

	// --------------------------------------------------------------
	// axi responses
	// --------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// --------------------------------------------------------------
	// carrier structs
	// --------------------------------------------------------------
	typedef struct packed {
		logic [FLAG_W-1:0] dout;
		logic [FLAG_W-1:0] oe_n;
	} pfp_pins_s;

	typedef struct packed {
		logic [DED_W-1:0] dedicated;
		logic fixed_out;
		logic fixed_sel;
	} pfp_fixed_s;

endpackage : pfp_pkg

//--- verif/pfp_pin_partner.sv
/*
 * far side of the flag pins: outside logic that resolves each flag wire.
 * assumes the bench supplies the levels the outside drives on input pins.
 */
module pfp_pin_partner (
	// pins from the device
	input wire pfp_pkg::pfp_pins_s pins,
	// levels the outside logic presents
	input wire logic [7:0] ext_level,
	// resolved wire levels
	output logic [7:0] pin_level
);
	// --------------------------------------------------------------
	// wire resolution
	// --------------------------------------------------------------
	// outside drives only pins the device leaves undriven, so no contention
	assign pin_level = (pins.dout & ~pins.oe_n) | (ext_level & pins.oe_n);
endmodule : pfp_pin_partner

//--- verif/pfp_flag_port_tb_top.sv
/*
 * self-checking bench for the flag port: axi4-lite master, random pins.
 * assumes the pin partner model and the design package are compiled first.
 */
module pfp_flag_port_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic arst_n = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, ext_level = 8'h00, pin_level;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	logic fixed_flag_input = 1'b0;
	logic [3:0] config_straps;
	pfp_pkg::pfp_pins_s pins;
	pfp_pkg::pfp_fixed_s fixed_flags;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;

	pfp_flag_port i_pfp_flag_port (.clk(clk), .arst_n(arst_n), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.programmable_flag_pin_in(pin_level), .programmable_flag_pin_out(pins),
		.fixed_flag_input(fixed_flag_input), .fixed_flags(fixed_flags),
		.config_straps(config_straps));
	pfp_pin_partner i_pfp_pin_partner (.pins(pins), .ext_level(ext_level),
		.pin_level(pin_level));

	// --------------------------------------------------------------
	// clock, hang guard, helpers
	// --------------------------------------------------------------
	always #50 clk = ~clk;

	// ceiling well above the few hundred cycles the run needs
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask : chk

	// outputs read back what is driven, inputs read the far side level
	function automatic logic [7:0] exp_val(logic [7:0] dir, logic [7:0] val, logic [7:0] ext);
		return (val & dir) | (ext & ~dir);
	endfunction : exp_val

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		// each channel is released at the edge that takes it
		do
		begin
			@(posedge clk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid && n < 50);
		r = bresp;
		bready <= 1'b0;
		if (n >= 50)
			fail_count++;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid && n < 50);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= 50)
			fail_count++;
	endtask : axi_read

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] dir, val, e, strap;
		logic [2:0] ded;
		// fall at time zero so the design's reset branch really runs
		arst_n <= 1'b0;
		void'($urandom(32'h9868));
		strap = 8'($urandom);
		ext_level <= strap;
		repeat (11) @(posedge clk);
		@(negedge clk);
		chk(pins.oe_n, 8'hFF);
		@(posedge clk);
		arst_n <= 1'b1;
		// straps stay on the low pins past the release edge
		repeat (3) @(posedge clk);
		axi_read(pfp_pkg::OFS_CONFIG, d, r);
		chk(d, {28'h0, strap[3:0]});
		chk(config_straps, strap[3:0]);
		chk(r, pfp_pkg::RESP_OKAY);
		axi_read(pfp_pkg::OFS_DIRECTION, d, r);
		chk(d, {24'h0, pfp_pkg::RST_DIRECTION});
		chk(r, pfp_pkg::RESP_OKAY);
		// random directions and values, all-in and all-out corners first
		for (int i = 0; i < 24; i++)
		begin
			dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
			val = 8'($urandom);
			e = 8'($urandom);
			ext_level <= e;
			axi_write(pfp_pkg::OFS_VALUE, {24'h0, val}, r);
			axi_write(pfp_pkg::OFS_DIRECTION, {24'h0, dir}, r);
			chk(r, pfp_pkg::RESP_OKAY);
			repeat (5) @(posedge clk);
			@(negedge clk);
			chk(pins.oe_n, 8'(~dir));
			chk(pin_level & dir, val & dir);
			axi_read(pfp_pkg::OFS_VALUE, d, r);
			chk(d, {24'h0, exp_val(dir, val, e)});
			chk(r, pfp_pkg::RESP_OKAY);
			axi_read(pfp_pkg::OFS_DIRECTION, d, r);
			chk(d, {24'h0, dir});
		end
		// fixed flags with the serial port alternate off, then on
		fixed_flag_input <= 1'b1;
		for (int s = 0; s < 2; s++)
		begin
			ded = 3'($urandom);
			axi_write(pfp_pkg::OFS_FIXED, 32'(ded) | 32'h08 | (32'(s) << 4), r);
			chk(r, pfp_pkg::RESP_OKAY);
			repeat (5) @(posedge clk);
			@(negedge clk);
			chk(fixed_flags.dedicated, ded);
			chk(fixed_flags.fixed_out, s[0]);
			chk(fixed_flags.fixed_sel, s[0]);
			axi_read(pfp_pkg::OFS_FIXED, d, r);
			chk({d[8], d[2:0]}, {s[0], ded});
		end
		// unmapped place and read-only place are refused
		axi_read(8'h10, d, r);
		chk({d, r}, {32'h0, pfp_pkg::RESP_SLVERR});
		axi_write(pfp_pkg::OFS_CONFIG, 32'hFF, r);
		chk(r, pfp_pkg::RESP_SLVERR);
		// reset in mid-run turns all-output pins back to inputs
		axi_write(pfp_pkg::OFS_DIRECTION, 32'hFF, r);
		@(posedge clk);
		arst_n <= 1'b0;
		@(negedge clk);
		chk(pins.oe_n, 8'hFF);
		@(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		axi_read(pfp_pkg::OFS_DIRECTION, d, r);
		chk(d, 32'h0);
		wrap_up();
	end
endmodule : pfp_flag_port_tb_top
